/* sysclk_consts.vh */
/*
 * Constants of the system clock and operating mode controller:
 * register offsets, field positions, reset values, state codes and counts.
 * Assumes inclusion by bare name from the controller source.
 */
`ifndef SCM_SYSCLK_CONSTS_VH
`define SCM_SYSCLK_CONSTS_VH

// Register byte offsets
`define SCM_ADDR_SYS_CLK_CTRL 12'h000
`define SCM_ADDR_HS_OSC_CTRL 12'h004
`define SCM_ADDR_INT_STATUS 12'h008
`define SCM_ADDR_INT_MASK 12'h00c
`define SCM_ADDR_SW_STATUS 12'h010

// Field positions in the system clock control register
`define SCM_SEL_HI 7
`define SCM_SEL_LO 5
`define SCM_HS_IDLE_BIT 1
`define SCM_LS_IDLE_BIT 0
// Field positions in the oscillator control register
`define SCM_STABLE_BIT 1
`define SCM_ENABLE_BIT 0

// Reset values
`define SCM_SEL_RST 3'h1
`define SCM_HS_IDLE_RST 1'h0
`define SCM_LS_IDLE_RST 1'h0
`define SCM_OSC_EN_RST 1'h1

// Field positions in the switch status register
`define SCM_STAT_MODE_HI 5
`define SCM_STAT_SEL_LO 0
`define SCM_STAT_SW_BIT 8

// Clock select code of the sub clock
`define SCM_SEL_SUB 3'h7

// Oscillator clocks until the stable flag sets
`define SCM_STABLE_CLKS 5'h10
// Current system clock periods before a switch may complete
`define SCM_SWITCH_CLKS 3'h4

// Operating mode codes
`define SCM_MODE_RUN 3'h0
`define SCM_MODE_SLEEP 3'h1
`define SCM_MODE_SUB_ONLY 3'h2
`define SCM_MODE_BOTH_ON 3'h3
`define SCM_MODE_FAST_ONLY 3'h4

// Interrupt bits
`define SCM_IRQ_STABLE 0
`define SCM_IRQ_SWITCH 1
`define SCM_IRQ_HALT 2
`define SCM_IRQ_W 3

`endif

/* scm_sysclk_ctrl.v */
/*
 * System clock selection and operating mode control with an APB slave.
 * Oscillator and sub clock arrive as one-cycle tick inputs synchronous
 * to pclk; every clock towards the CPU and peripherals leaves as a
 * registered one-cycle tick (a clock enable), or as a registered level for pwm_clk_en and cpu_run, never as a gated clock.
 * The CPU gives single-cycle halt and wake pulses.
 */
// Functional notes
// RQ1: select field codes 0-6 give fast clock divided by 1..64, code 7 sub clock.
// RQ2: halt with both idle bits 0 stops CPU, system, fast and sub clocks.
// RQ3: halt, fast idle 0, slow idle 1: fast off, sub on, system only on sub.
// RQ4: halt with both idle bits 1 keeps fast, sub and system clocks on.
// RQ5: halt, fast idle 1, slow idle 0: sub off, fast on, system only fast.
// RQ6: while running idle bits ignored; slow mode fast clock follows enable bit.
// RQ7: fast oscillator off gives no fast, divided or pwm clocks to peripherals.
// RQ8: watchdog slow clock runs always, sleep included, watchdog always enabled.
// RQ9: enabling oscillator clears stable flag, sets it after 16 oscillator clocks.
// RQ10: oscillator runs when enable bit is 1, stops when 0; the code obeys the bit only in run mode with select code 7.
// RQ11: unimplemented bits of both clock control registers read as zero.
// RQ12: clock switch completes after four current periods plus a target edge.
// RQ13: software waits for stable flag before relying on returning fast clock.
// RQ14: halt is one pulse; idle bits sampled then choose the power-down mode.
`include "sysclk_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module scm_sysclk_ctrl #(
    parameter DIV_N = 7
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire hs_osc_tick,
    input wire sub_osc_tick,
    input wire halt_req,
    input wire wake_req,
    output reg hs_osc_run,
    output reg cpu_run,
    output reg system_clk_tick,
    output reg high_speed_clk_tick,
    output reg [DIV_N-2:0] hs_div_tick,
    output reg pwm_clk_en,
    output reg sub_clk_tick,
    output reg watchdog_slow_clk_tick,
    output reg irq
);
    // Software-visible control state and the stable flag counter
    reg [2:0] sel_ff;
    reg hs_idle_ff;
    reg ls_idle_ff;
    reg osc_en_ff;
    reg stable_ff;
    reg [4:0] stable_cnt_ff;
    reg [`SCM_IRQ_W-1:0] int_status_ff;
    reg [`SCM_IRQ_W-1:0] int_mask_ff;
    // Clock path state
    reg [2:0] act_sel_ff;
    reg switching_ff;
    reg [2:0] sw_cnt_ff;
    reg [2:0] mode_ff;
    reg [5:0] div_cnt_ff;
    // Combinational terms
    reg [2:0] nxt_mode;
    reg hs_on;
    reg sub_on;
    reg sys_on;
    reg sys_src_tick;
    reg tgt_tick;
    reg [31:0] rd_data;
    reg rd_hit;
    wire wr_en;
    wire switch_done;
    wire stable_set;
    wire [`SCM_IRQ_W-1:0] events;
    wire [DIV_N-1:0] div_hit;

    assign wr_en = psel & penable & pready & pwrite;

    // Tick of the fast clock divided by 2**i
    genvar gi;
    generate
        for (gi = 0; gi < DIV_N; gi = gi + 1) begin : g_div
            if (gi == 0) begin : g_one
                assign div_hit[gi] = hs_osc_tick;
            end else begin : g_more
                assign div_hit[gi] = hs_osc_tick & (div_cnt_ff[gi-1:0] == {gi{1'b0}});
            end
        end
    endgenerate

    // Oscillator, sub and system clock gating per mode
    always @* begin
        hs_on = 1'b0;
        sub_on = 1'b0;
        sys_on = 1'b0;
        case (mode_ff)
            `SCM_MODE_RUN: begin
                hs_on = (act_sel_ff != `SCM_SEL_SUB) | osc_en_ff; // see RQ6 RQ10
                sub_on = 1'b1;
                sys_on = 1'b1;
            end
            `SCM_MODE_SUB_ONLY: begin
                sub_on = 1'b1; // see RQ3
                sys_on = (act_sel_ff == `SCM_SEL_SUB);
            end
            `SCM_MODE_BOTH_ON: begin
                hs_on = 1'b1; // see RQ4
                sub_on = 1'b1;
                sys_on = 1'b1;
            end
            `SCM_MODE_FAST_ONLY: begin
                hs_on = 1'b1; // see RQ5
                sys_on = (act_sel_ff != `SCM_SEL_SUB);
            end
            default: begin
                hs_on = 1'b0; // see RQ2
            end
        endcase
    end

    // Source ticks of current and target system clocks
    always @* begin
        if (act_sel_ff == `SCM_SEL_SUB) begin
            sys_src_tick = sub_osc_tick;
        end else begin
            sys_src_tick = div_hit[act_sel_ff] & hs_on & stable_ff; // see RQ1
        end
        if (sel_ff == `SCM_SEL_SUB) begin
            tgt_tick = sub_osc_tick;
        end else begin
            tgt_tick = div_hit[sel_ff] & hs_on & stable_ff;
        end
    end

    // Switch completes on a target edge after four current periods
    assign switch_done = switching_ff & (sw_cnt_ff == `SCM_SWITCH_CLKS) & tgt_tick; // see RQ12
    assign stable_set = hs_on & ~stable_ff & hs_osc_tick & (stable_cnt_ff == `SCM_STABLE_CLKS - 5'h1);
    assign events = {mode_ff == `SCM_MODE_RUN && halt_req, switch_done, stable_set};

    // Power-down mode chosen from idle bits at the halt pulse
    always @* begin
        nxt_mode = mode_ff;
        if (mode_ff == `SCM_MODE_RUN) begin
            if (halt_req) begin
                case ({hs_idle_ff, ls_idle_ff}) // see RQ14
                    2'b00: nxt_mode = `SCM_MODE_SLEEP; // see RQ2
                    2'b01: nxt_mode = `SCM_MODE_SUB_ONLY; // see RQ3
                    2'b11: nxt_mode = `SCM_MODE_BOTH_ON; // see RQ4
                    default: nxt_mode = `SCM_MODE_FAST_ONLY; // see RQ5
                endcase
            end
        end else if (wake_req) begin
            nxt_mode = `SCM_MODE_RUN;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= `SCM_MODE_RUN;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // Register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff <= `SCM_SEL_RST;
            hs_idle_ff <= `SCM_HS_IDLE_RST;
            ls_idle_ff <= `SCM_LS_IDLE_RST;
            osc_en_ff <= `SCM_OSC_EN_RST;
            int_mask_ff <= {`SCM_IRQ_W{1'b0}};
        end else if (wr_en) begin
            if (paddr == `SCM_ADDR_SYS_CLK_CTRL) begin
                sel_ff <= pwdata[`SCM_SEL_HI:`SCM_SEL_LO];
                hs_idle_ff <= pwdata[`SCM_HS_IDLE_BIT];
                ls_idle_ff <= pwdata[`SCM_LS_IDLE_BIT];
            end
            if (paddr == `SCM_ADDR_HS_OSC_CTRL) begin
                osc_en_ff <= pwdata[`SCM_ENABLE_BIT]; // see RQ10
            end
            if (paddr == `SCM_ADDR_INT_MASK) begin
                int_mask_ff <= pwdata[`SCM_IRQ_W-1:0];
            end
        end
    end

    // Sticky status, set wins over write-one-to-clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_ff <= {`SCM_IRQ_W{1'b0}};
        end else if (wr_en && paddr == `SCM_ADDR_INT_STATUS) begin
            int_status_ff <= (int_status_ff & ~pwdata[`SCM_IRQ_W-1:0]) | events;
        end else begin
            int_status_ff <= int_status_ff | events;
        end
    end

    // Stable flag: cleared while oscillator off, set after 16 clocks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_ff <= 1'b0;
            stable_cnt_ff <= 5'h0;
        end else if (!hs_on) begin
            stable_ff <= 1'b0; // see RQ9
            stable_cnt_ff <= 5'h0;
        end else if (stable_set) begin
            stable_ff <= 1'b1; // see RQ9
        end else if (!stable_ff && hs_osc_tick) begin
            stable_cnt_ff <= stable_cnt_ff + 5'h1;
        end
    end

    // Divider counts fast clock ticks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_ff <= 6'h0;
        end else if (hs_osc_tick) begin
            div_cnt_ff <= div_cnt_ff + 6'h1;
        end
    end

    // Clock switch sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_sel_ff <= `SCM_SEL_RST;
            switching_ff <= 1'b0;
            sw_cnt_ff <= 3'h0;
        end else if (sel_ff != act_sel_ff && !switching_ff) begin
            switching_ff <= 1'b1;
            sw_cnt_ff <= 3'h0;
        end else if (switching_ff) begin
            if (switch_done) begin
                act_sel_ff <= sel_ff;
                switching_ff <= 1'b0;
            end else if (sw_cnt_ff != `SCM_SWITCH_CLKS && sys_src_tick) begin
                sw_cnt_ff <= sw_cnt_ff + 3'h1; // see RQ12
            end
        end
    end

    // Registered clock ticks and enables to the outside
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_osc_run <= 1'b0;
            cpu_run <= 1'b0;
            system_clk_tick <= 1'b0;
            high_speed_clk_tick <= 1'b0;
            hs_div_tick <= {(DIV_N-1){1'b0}};
            pwm_clk_en <= 1'b0;
            sub_clk_tick <= 1'b0;
            watchdog_slow_clk_tick <= 1'b0;
            irq <= 1'b0;
        end else begin
            hs_osc_run <= hs_on; // see RQ10
            cpu_run <= (nxt_mode == `SCM_MODE_RUN);
            system_clk_tick <= sys_on & sys_src_tick;
            high_speed_clk_tick <= hs_on & stable_ff & hs_osc_tick; // see RQ7
            hs_div_tick <= div_hit[DIV_N-1:1] & {(DIV_N-1){hs_on & stable_ff}}; // see RQ7
            pwm_clk_en <= hs_on & stable_ff; // see RQ7
            sub_clk_tick <= sub_on & sub_osc_tick;
            watchdog_slow_clk_tick <= sub_osc_tick; // see RQ8
            irq <= |(int_status_ff & int_mask_ff);
        end
    end

    // Read mux
    always @* begin
        rd_data = 32'h0;
        rd_hit = 1'b1;
        case (paddr)
            `SCM_ADDR_SYS_CLK_CTRL: begin
                rd_data[`SCM_SEL_HI:`SCM_SEL_LO] = sel_ff; // see RQ11
                rd_data[`SCM_HS_IDLE_BIT] = hs_idle_ff;
                rd_data[`SCM_LS_IDLE_BIT] = ls_idle_ff;
            end
            `SCM_ADDR_HS_OSC_CTRL: begin
                rd_data[`SCM_STABLE_BIT] = stable_ff; // see RQ11 RQ13
                rd_data[`SCM_ENABLE_BIT] = osc_en_ff;
            end
            `SCM_ADDR_INT_STATUS: begin
                rd_data[`SCM_IRQ_W-1:0] = int_status_ff;
            end
            `SCM_ADDR_INT_MASK: begin
                rd_data[`SCM_IRQ_W-1:0] = int_mask_ff;
            end
            `SCM_ADDR_SW_STATUS: begin
                rd_data[`SCM_STAT_MODE_HI:`SCM_STAT_SEL_LO] = {mode_ff, act_sel_ff};
                rd_data[`SCM_STAT_SW_BIT] = switching_ff;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // APB answer: one access cycle, data loaded in setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_hit;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0 : rd_data;
            end
        end
    end

endmodule // scm_sysclk_ctrl

`default_nettype wire

/* scm_sysclk_monitor.sv */
/* Port checker of the clock mode controller.
   Assumes binding onto scm_sysclk_ctrl with oscillator ticks from a model. */
`timescale 1ns/1ps
`default_nettype none
module scm_sysclk_monitor #(
    parameter DIV_N = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hs_osc_tick,
    input wire logic sub_osc_tick,
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic hs_osc_run,
    input wire logic cpu_run,
    input wire logic system_clk_tick,
    input wire logic high_speed_clk_tick,
    input wire logic [DIV_N-2:0] hs_div_tick,
    input wire logic pwm_clk_en,
    input wire logic sub_clk_tick,
    input wire logic watchdog_slow_clk_tick
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Clock relations
    AST_WDG_FOLLOW: assert property (sub_osc_tick |=> watchdog_slow_clk_tick)
        else $error("watchdog tick missing");
    AST_HALT_STOPS: assert property (cpu_run && halt_req |-> ##[1:2] !cpu_run)
        else $error("cpu kept running after halt");
    AST_NO_FAST_OFF: assert property (!hs_osc_run [*3] |-> !high_speed_clk_tick && !(|hs_div_tick) && !pwm_clk_en)
        else $error("fast clock while oscillator off");
    AST_STABLE_WAIT: assert property ($rose(hs_osc_run) |=> !high_speed_clk_tick [*8])
        else $error("fast clock before stable");
    AST_DIV64_RATE: assert property (hs_div_tick[DIV_N-2] |=> !hs_div_tick[DIV_N-2] [*8])
        else $error("slowest divided tick too fast");
    AST_FAST_SRC: assert property (high_speed_clk_tick |-> $past(hs_osc_tick))
        else $error("fast tick without oscillator tick");
    AST_SUB_SRC: assert property (sub_clk_tick |-> $past(sub_osc_tick))
        else $error("sub tick without slow tick");
    AST_SYS_SRC: assert property (system_clk_tick |-> $past(hs_osc_tick) || $past(sub_osc_tick))
        else $error("system tick without source tick");
    // Main scenarios
    cover property (cpu_run && halt_req);
    cover property (!cpu_run && wake_req);
    cover property (pready && pslverr);
endmodule // scm_sysclk_monitor
bind scm_sysclk_ctrl scm_sysclk_monitor #(.DIV_N(DIV_N)) u_mon (.pclk(pclk), .presetn(presetn),
    .pready(pready), .pslverr(pslverr), .hs_osc_tick(hs_osc_tick), .sub_osc_tick(sub_osc_tick),
    .halt_req(halt_req), .wake_req(wake_req), .hs_osc_run(hs_osc_run), .cpu_run(cpu_run),
    .system_clk_tick(system_clk_tick), .high_speed_clk_tick(high_speed_clk_tick),
    .hs_div_tick(hs_div_tick), .pwm_clk_en(pwm_clk_en), .sub_clk_tick(sub_clk_tick),
    .watchdog_slow_clk_tick(watchdog_slow_clk_tick));
`default_nettype wire

/* scm_osc_model.sv */
/* Model of the two oscillators as pclk tick sources.
   Assumes the controller's enable level gates the fast one. */
`timescale 1ns/1ps
`default_nettype none
module scm_osc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hs_osc_run,
    output logic hs_osc_tick,
    output logic sub_osc_tick
);
    logic [2:0] cnt_ff;
    // Fast tick every 2nd cycle, slow every 8th
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 3'h0;
            hs_osc_tick <= 1'b0;
            sub_osc_tick <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
            hs_osc_tick <= hs_osc_run & cnt_ff[0];
            sub_osc_tick <= (cnt_ff == 3'h7);
        end
    end
endmodule // scm_osc_model
`default_nettype wire

/* system_clock_mode_control_test.sv */
/* Self-checking bench of the clock mode controller.
   Assumes the oscillator model and the bound checker. */
`include "sysclk_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module system_clock_mode_control_test;
    logic pclk, presetn, psel, penable, pwrite, halt_req, wake_req, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    wire pready, pslverr, hs_osc_tick, sub_osc_tick, hs_osc_run, cpu_run, system_clk_tick;
    wire high_speed_clk_tick, pwm_clk_en, sub_clk_tick, watchdog_slow_clk_tick, irq;
    wire [5:0] hs_div_tick;
    int mismatches = 0;
    int check_count = 0;
    scm_sysclk_ctrl #(.DIV_N(7)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hs_osc_tick(hs_osc_tick), .sub_osc_tick(sub_osc_tick),
        .halt_req(halt_req), .wake_req(wake_req), .hs_osc_run(hs_osc_run), .cpu_run(cpu_run),
        .system_clk_tick(system_clk_tick), .high_speed_clk_tick(high_speed_clk_tick),
        .hs_div_tick(hs_div_tick), .pwm_clk_en(pwm_clk_en), .sub_clk_tick(sub_clk_tick),
        .watchdog_slow_clk_tick(watchdog_slow_clk_tick), .irq(irq));
    scm_osc_model u_osc (.pclk(pclk), .presetn(presetn), .hs_osc_run(hs_osc_run),
        .hs_osc_tick(hs_osc_tick), .sub_osc_tick(sub_osc_tick));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("mismatch pready expected 1 seen %b", pready);
            results;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task pulse(input logic h);
        if (h) halt_req <= 1'b1;
        else wake_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
    endtask
    // Ticks seen over 128 cycles
    task cnt(output int s, output int h, output int u, output int w);
        s = 0;
        h = 0;
        u = 0;
        w = 0;
        repeat (128) begin
            @(posedge pclk);
            s += system_clk_tick;
            h += high_speed_clk_tick | (|hs_div_tick) | pwm_clk_en;
            u += sub_clk_tick;
            w += watchdog_slow_clk_tick;
        end
    endtask
    task t_regs;
        tick(40);
        apb(0, `SCM_ADDR_SYS_CLK_CTRL, 0);
        chk("sys reset", 32'h20, r);
        apb(0, `SCM_ADDR_HS_OSC_CTRL, 0);
        chk("osc reset", 32'h3, r);
        apb(1, `SCM_ADDR_SYS_CLK_CTRL, 32'hffffffff);
        apb(0, `SCM_ADDR_SYS_CLK_CTRL, 0);
        chk("sys ones", 32'he3, r);
        apb(1, `SCM_ADDR_HS_OSC_CTRL, 32'hffffffff);
        apb(0, `SCM_ADDR_HS_OSC_CTRL, 0);
        chk("osc ones", 32'h3, r);
        apb(0, 12'h0fc, 0);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, r);
        $display("t_regs done");
    endtask
    task t_irq;
        apb(1, `SCM_ADDR_INT_MASK, 32'h4);
        apb(1, `SCM_ADDR_INT_STATUS, 32'h7);
        tick(2);
        chk("irq clear", 0, irq);
        pulse(1);
        tick(3);
        chk("irq halt", 1, irq);
        pulse(0);
        apb(1, `SCM_ADDR_INT_MASK, 0);
        tick(2);
        chk("irq masked", 0, irq);
        apb(1, `SCM_ADDR_INT_STATUS, 32'h4);
        apb(1, `SCM_ADDR_INT_MASK, 32'h4);
        tick(2);
        chk("irq w1c", 0, irq);
        $display("t_irq done");
    endtask
    // Every idle bit pair with a fast and the sub select
    task t_pd;
        int i, s, h, u, w;
        logic sb, hb, lb;
        for (i = 0; i < 8; i++) begin
            sb = i[2];
            hb = i[1];
            lb = i[0];
            apb(1, `SCM_ADDR_SYS_CLK_CTRL, {24'h0, sb ? `SCM_SEL_SUB : 3'h0, 3'h0, hb, lb});
            tick(100);
            apb(0, `SCM_ADDR_SW_STATUS, 0);
            chk("active sel", sb ? 32'h7 : 32'h0, r);
            pulse(1);
            tick(4);
            cnt(s, h, u, w);
            chk("cpu_run", 0, cpu_run);
            chk("sys clk", (hb & lb) | (lb & sb) | (hb & !sb), s > 0);
            chk("fast clk", hb, h > 0);
            chk("sub clk", lb, u > 0);
            chk("wdg clk", 1, w > 0);
            pulse(0);
            tick(60);
        end
        $display("t_pd done");
    endtask
    // Every fast divisor: system ticks over 128 cycles
    task t_div;
        int k, s, h, u, w;
        for (k = 0; k < 7; k++) begin
            apb(1, `SCM_ADDR_SYS_CLK_CTRL, {24'h0, k[2:0], 5'h0});
            tick(420);
            cnt(s, h, u, w);
            chk("div ticks", 32'h40 >> k, s);
        end
        apb(1, `SCM_ADDR_SYS_CLK_CTRL, 32'he0);
        tick(700);
        apb(0, `SCM_ADDR_SW_STATUS, 0);
        chk("slow status", 32'h7, r);
        $display("t_div done");
    endtask
    task t_osc;
        int s, h, u, w;
        apb(1, `SCM_ADDR_SYS_CLK_CTRL, 32'he0);
        tick(100);
        apb(1, `SCM_ADDR_HS_OSC_CTRL, 0);
        tick(4);
        chk("osc off", 0, hs_osc_run);
        cnt(s, h, u, w);
        chk("fast clks", 0, h > 0);
        chk("slow sys", 1, s > 0);
        apb(0, `SCM_ADDR_HS_OSC_CTRL, 0);
        chk("osc reg off", 0, r);
        apb(1, `SCM_ADDR_HS_OSC_CTRL, 1);
        apb(0, `SCM_ADDR_HS_OSC_CTRL, 0);
        chk("flag cleared", 1, r);
        tick(60);
        apb(0, `SCM_ADDR_HS_OSC_CTRL, 0);
        chk("flag set", 3, r);
        chk("osc on", 1, hs_osc_run);
        $display("t_osc done");
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        halt_req = 1'b0;
        wake_req = 1'b0;
        tick(16);
        presetn <= 1'b1;
        t_regs;
        t_irq;
        t_pd;
        t_div;
        t_osc;
        results;
    end
    // Hang guard, about three times the expected run
    initial begin
        #80000;
        mismatches++;
        results;
    end
endmodule // system_clock_mode_control_test
`default_nettype wire
